/* File: design/jti_pkg.sv */
// package: constants and types for the test access port instruction logic
// Function
// - instruction register is three bits, eight codes
// - new instruction takes effect at Update-IR only
// - identification code shifts out in Shift-DR
// - identification instruction after reset and Test-Logic-Reset
// - high-Z sample selects boundary chain, floats bus
// - sample/preload captures pins in Capture-DR
// - captured boundary data shifts out in Shift-DR
// - preload latches pattern into parallel outputs
// - shift in new data while old shifts out
// - bypass places single bit between TDI, TDO
// - external test drives preloaded values onto pins
// - cell 108 latched at Update-DR controls bus
// - cell one drives bus, zero floats it
// - cell 108 cleared at reset and Test-Logic-Reset
// - decode 000,001,010,100,111; others reserved
// - Capture-IR loads 01 into low bits
// - scan registers shift in at MSB, out LSB
// - five TMS-high rising edges reset the port
package jti_pkg;

  localparam int unsigned IR_W      = 3;
  localparam int unsigned ID_W      = 32;
  localparam int unsigned BSR_LEN   = 109;
  localparam int unsigned PIN_CNT   = 108;
  localparam int unsigned OE_CELL   = 108;
  localparam int unsigned TLR_EDGES = 5;

  localparam logic [IR_W-1:0] OP_EXTEST  = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE  = 3'h1;
  localparam logic [IR_W-1:0] OP_HIGHZ   = 3'h2;
  localparam logic [IR_W-1:0] OP_SAMPLE  = 3'h4;
  localparam logic [IR_W-1:0] OP_BYPASS  = 3'h7;
  localparam logic [IR_W-1:0] IR_RESET   = OP_IDCODE;
  localparam logic [1:0]      IR_CAPTURE = 2'h1;
  localparam logic            OE_RESET   = 1'h0;

  // identification value is arbitrary; bit 0 marks presence of the register
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0abc_d001;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jti_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jti_link_t;

endpackage

/* File: design/jti_tap.sv */
// module: test access port sequencer, instruction decode and scan registers
`timescale 1ns/10ps
module jti_tap (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  // test link pins
  input  wire jti_pkg::jti_link_t            link_in,
  output logic                               tdo_ff,
  output logic                               tdo_oe_ff,
  // boundary pins
  input  wire logic [jti_pkg::PIN_CNT-1:0]   pin_in,
  output logic [jti_pkg::PIN_CNT-1:0]        pin_drive_ff,
  output logic                               test_drive_ff,
  output logic                               rdata_oe_ff
);

  jti_pkg::jti_link_t                link_s1_ff;
  jti_pkg::jti_link_t                link_s2_ff;
  logic                              tck_prev_ff;
  logic [jti_pkg::PIN_CNT-1:0]       pin_s1_ff;
  logic [jti_pkg::PIN_CNT-1:0]       pin_s2_ff;
  jti_pkg::jti_state_t               state_ff;
  jti_pkg::jti_state_t               nxt_state;
  logic [jti_pkg::IR_W-1:0]          ir_ff;
  logic [jti_pkg::IR_W-1:0]          ir_shift_ff;
  logic [jti_pkg::ID_W-1:0]          id_shift_ff;
  logic                              byp_ff;
  logic [jti_pkg::BSR_LEN-1:0]       bsr_ff;
  logic [jti_pkg::BSR_LEN-1:0]       preload_ff;
  logic [2:0]                        tms_run_ff;
  logic                              tck_rise;
  logic                              tck_fall;
  logic                              tms_s;
  logic                              tdi_s;

  // boundary chain is selected by extest, high-Z sample and sample/preload
  function automatic logic uses_bsr(input logic [jti_pkg::IR_W-1:0] op);
    uses_bsr = (op == jti_pkg::OP_EXTEST) || (op == jti_pkg::OP_HIGHZ) || (op == jti_pkg::OP_SAMPLE);
  endfunction

  // reserved codes fall back to bypass so the chain length stays defined
  function automatic logic dr_serial_out(input logic [jti_pkg::IR_W-1:0] op,
                                         input logic [jti_pkg::ID_W-1:0] id_v,
                                         input logic [jti_pkg::BSR_LEN-1:0] bsr_v,
                                         input logic byp_v);
    if (uses_bsr(op)) begin
      dr_serial_out = bsr_v[0];
    end else if (op == jti_pkg::OP_IDCODE) begin
      dr_serial_out = id_v[0];
    end else begin
      dr_serial_out = byp_v;
    end
  endfunction

  // link pins arrive from another clock; only the second stage is read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_s1_ff  <= '0;
      link_s2_ff  <= '0;
      tck_prev_ff <= 1'h0;
    end else begin
      link_s1_ff  <= link_in;
      link_s2_ff  <= link_s1_ff;
      tck_prev_ff <= link_s2_ff.tck;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= pin_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign tck_rise = link_s2_ff.tck & ~tck_prev_ff;
  assign tck_fall = ~link_s2_ff.tck & tck_prev_ff;
  assign tms_s    = link_s2_ff.tms;
  assign tdi_s    = link_s2_ff.tdi;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      jti_pkg::ST_TLR:    nxt_state = tms_s ? jti_pkg::ST_TLR    : jti_pkg::ST_RTI;
      jti_pkg::ST_RTI:    nxt_state = tms_s ? jti_pkg::ST_SEL_DR : jti_pkg::ST_RTI;
      jti_pkg::ST_SEL_DR: nxt_state = tms_s ? jti_pkg::ST_SEL_IR : jti_pkg::ST_CAP_DR;
      jti_pkg::ST_CAP_DR: nxt_state = tms_s ? jti_pkg::ST_EX1_DR : jti_pkg::ST_SHF_DR;
      jti_pkg::ST_SHF_DR: nxt_state = tms_s ? jti_pkg::ST_EX1_DR : jti_pkg::ST_SHF_DR;
      jti_pkg::ST_EX1_DR: nxt_state = tms_s ? jti_pkg::ST_UPD_DR : jti_pkg::ST_PAU_DR;
      jti_pkg::ST_PAU_DR: nxt_state = tms_s ? jti_pkg::ST_EX2_DR : jti_pkg::ST_PAU_DR;
      jti_pkg::ST_EX2_DR: nxt_state = tms_s ? jti_pkg::ST_UPD_DR : jti_pkg::ST_SHF_DR;
      jti_pkg::ST_UPD_DR: nxt_state = tms_s ? jti_pkg::ST_SEL_DR : jti_pkg::ST_RTI;
      jti_pkg::ST_SEL_IR: nxt_state = tms_s ? jti_pkg::ST_TLR    : jti_pkg::ST_CAP_IR;
      jti_pkg::ST_CAP_IR: nxt_state = tms_s ? jti_pkg::ST_EX1_IR : jti_pkg::ST_SHF_IR;
      jti_pkg::ST_SHF_IR: nxt_state = tms_s ? jti_pkg::ST_EX1_IR : jti_pkg::ST_SHF_IR;
      jti_pkg::ST_EX1_IR: nxt_state = tms_s ? jti_pkg::ST_UPD_IR : jti_pkg::ST_PAU_IR;
      jti_pkg::ST_PAU_IR: nxt_state = tms_s ? jti_pkg::ST_EX2_IR : jti_pkg::ST_PAU_IR;
      jti_pkg::ST_EX2_IR: nxt_state = tms_s ? jti_pkg::ST_UPD_IR : jti_pkg::ST_SHF_IR;
      jti_pkg::ST_UPD_IR: nxt_state = tms_s ? jti_pkg::ST_SEL_DR : jti_pkg::ST_RTI;
      default:            nxt_state = jti_pkg::ST_TLR;
    endcase
  end

  // sequencer advances only on a sampled rising test-clock edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= jti_pkg::ST_TLR;
    end else if (tck_rise) begin
      state_ff <= nxt_state;
    end
  end

  // helper for the reset check: consecutive rising edges with TMS high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tms_run_ff <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s) begin
        tms_run_ff <= 3'h0;
      end else if (tms_run_ff != 3'h7) begin
        tms_run_ff <= tms_run_ff + 3'h1;
      end
    end
  end

  // instruction shift stage; bit 2 is cleared on capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift_ff <= '0;
    end else if (tck_rise) begin
      if (state_ff == jti_pkg::ST_CAP_IR) begin
        ir_shift_ff <= {1'h0, jti_pkg::IR_CAPTURE};
      end else if (state_ff == jti_pkg::ST_SHF_IR) begin
        ir_shift_ff <= {tdi_s, ir_shift_ff[jti_pkg::IR_W-1:1]};
      end
    end
  end

  // current instruction; Test-Logic-Reset is synchronous so TCK must run to reach it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_ff <= jti_pkg::IR_RESET;
    end else if (state_ff == jti_pkg::ST_TLR) begin
      ir_ff <= jti_pkg::IR_RESET;
    end else if (tck_rise && state_ff == jti_pkg::ST_UPD_IR) begin
      ir_ff <= ir_shift_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      id_shift_ff <= '0;
    end else if (tck_rise && ir_ff == jti_pkg::OP_IDCODE) begin
      if (state_ff == jti_pkg::ST_CAP_DR) begin
        id_shift_ff <= jti_pkg::ID_VALUE;
      end else if (state_ff == jti_pkg::ST_SHF_DR) begin
        id_shift_ff <= {tdi_s, id_shift_ff[jti_pkg::ID_W-1:1]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_ff <= 1'h0;
    end else if (tck_rise && !uses_bsr(ir_ff) && ir_ff != jti_pkg::OP_IDCODE) begin
      if (state_ff == jti_pkg::ST_CAP_DR) begin
        byp_ff <= 1'h0;
      end else if (state_ff == jti_pkg::ST_SHF_DR) begin
        byp_ff <= tdi_s;
      end
    end
  end

  // pins are sampled two ref_clk cycles late; unstable pins give no guaranteed value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bsr_ff <= '0;
    end else if (tck_rise && uses_bsr(ir_ff)) begin
      if (state_ff == jti_pkg::ST_CAP_DR) begin
        bsr_ff <= {preload_ff[jti_pkg::OE_CELL], pin_s2_ff};
      end else if (state_ff == jti_pkg::ST_SHF_DR) begin
        bsr_ff <= {tdi_s, bsr_ff[jti_pkg::BSR_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      preload_ff <= '0;
    end else if (state_ff == jti_pkg::ST_TLR) begin
      preload_ff[jti_pkg::OE_CELL] <= jti_pkg::OE_RESET;
    end else if (tck_rise && state_ff == jti_pkg::ST_UPD_DR &&
                 (ir_ff == jti_pkg::OP_SAMPLE || ir_ff == jti_pkg::OP_EXTEST)) begin
      preload_ff <= bsr_ff;
    end
  end

  // test drive and bus enable follow the current instruction, pins always follow preload; outside test the memory owns the bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_drive_ff  <= '0;
      test_drive_ff <= 1'h0;
      rdata_oe_ff   <= 1'h1;
    end else begin
      pin_drive_ff  <= preload_ff[jti_pkg::PIN_CNT-1:0];
      test_drive_ff <= (ir_ff == jti_pkg::OP_EXTEST);
      if (ir_ff == jti_pkg::OP_EXTEST) begin
        rdata_oe_ff <= preload_ff[jti_pkg::OE_CELL];
      end else begin
        rdata_oe_ff <= (ir_ff != jti_pkg::OP_HIGHZ);
      end
    end
  end

  // TDO is updated half a test clock after the shift edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_ff    <= 1'h0;
      tdo_oe_ff <= 1'h0;
    end else if (tck_fall) begin
      tdo_oe_ff <= (state_ff == jti_pkg::ST_SHF_IR) || (state_ff == jti_pkg::ST_SHF_DR);
      if (state_ff == jti_pkg::ST_SHF_IR) begin
        tdo_ff <= ir_shift_ff[0];
      end else begin
        tdo_ff <= dr_serial_out(ir_ff, id_shift_ff, bsr_ff, byp_ff);
      end
    end
  end

  ir_update_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(tck_rise && state_ff == jti_pkg::ST_UPD_IR) && state_ff != jti_pkg::ST_TLR |=> $stable(ir_ff))
    else $error("instruction changed outside update");

  tlr_idcode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_ff == jti_pkg::ST_TLR |=> ir_ff == jti_pkg::OP_IDCODE && !preload_ff[jti_pkg::OE_CELL])
    else $error("reset state did not restore instruction and cell");

  ir_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_rise && state_ff == jti_pkg::ST_CAP_IR |=> ir_shift_ff == 3'h1)
    else $error("capture pattern wrong");

  tdo_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(tdo_ff) || $changed(tdo_oe_ff) |-> $past(tck_fall))
    else $error("tdo changed off a falling edge");

  tms_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tms_run_ff >= 3'h5 |-> state_ff == jti_pkg::ST_TLR)
    else $error("five high tms edges did not reset");

  id_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_rise && state_ff == jti_pkg::ST_CAP_DR && ir_ff == jti_pkg::OP_IDCODE |=> id_shift_ff == 32'h0abc_d001)
    else $error("identification capture wrong");

  bypass_shift_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_rise && state_ff == jti_pkg::ST_SHF_DR && ir_ff == jti_pkg::OP_BYPASS |=> byp_ff == $past(tdi_s))
    else $error("bypass did not take tdi");

  bsr_shift_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_rise && state_ff == jti_pkg::ST_SHF_DR && uses_bsr(ir_ff)
    |=> bsr_ff == {$past(tdi_s), $past(bsr_ff[jti_pkg::BSR_LEN-1:1])})
    else $error("boundary chain shift wrong");

  pin_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_rise && state_ff == jti_pkg::ST_CAP_DR && ir_ff == jti_pkg::OP_SAMPLE
    |=> bsr_ff[jti_pkg::PIN_CNT-1:0] == $past(pin_s2_ff))
    else $error("pins not captured");

  preload_upd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_rise && state_ff == jti_pkg::ST_UPD_DR && ir_ff == jti_pkg::OP_SAMPLE |=> preload_ff == $past(bsr_ff))
    else $error("preload not latched at update");

  highz_bus_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ir_ff == jti_pkg::OP_HIGHZ |=> !rdata_oe_ff)
    else $error("bus not floated under high-z sample");

  extest_oe_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ir_ff == jti_pkg::OP_EXTEST |=> test_drive_ff && rdata_oe_ff == $past(preload_ff[jti_pkg::OE_CELL]))
    else $error("bus enable does not follow cell under extest");

  tdo_oe_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_fall && (state_ff == jti_pkg::ST_SHF_IR || state_ff == jti_pkg::ST_SHF_DR) |=> tdo_oe_ff)
    else $error("tdo not driven while shifting");

  tdo_oe_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_fall && state_ff == jti_pkg::ST_RTI |=> !tdo_oe_ff)
    else $error("tdo driven while idle");

  ir_tdo_lsb_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_fall && state_ff == jti_pkg::ST_SHF_IR |=> tdo_ff == $past(ir_shift_ff[0]))
    else $error("instruction lsb not on tdo");

  id_tdo_lsb_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_fall && state_ff == jti_pkg::ST_SHF_DR && ir_ff == jti_pkg::OP_IDCODE
    |=> tdo_ff == $past(id_shift_ff[0]))
    else $error("identification lsb not on tdo");

  rsvd_bypass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_fall && state_ff == jti_pkg::ST_SHF_DR && !uses_bsr(ir_ff) && ir_ff != jti_pkg::OP_IDCODE
    |=> tdo_ff == $past(byp_ff))
    else $error("bypass or reserved code not on one-bit chain");

  bypass_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck_rise && state_ff == jti_pkg::ST_CAP_DR && ir_ff == jti_pkg::OP_BYPASS |=> !byp_ff)
    else $error("bypass bit not cleared on capture");

  extest_pins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ir_ff == jti_pkg::OP_EXTEST |=> pin_drive_ff == $past(preload_ff[jti_pkg::PIN_CNT-1:0]))
    else $error("pins do not follow preload under extest");

  sample_bus_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ir_ff == jti_pkg::OP_SAMPLE |=> rdata_oe_ff)
    else $error("bus disturbed under sample");

endmodule // jti_tap

/* File: verification/jti_ctl_model.sv */
// behavioural board test controller that drives the test link
`timescale 1ns/10ps
module jti_ctl_model (
  // system clock, used only to pace the link
  input  wire logic          ref_clk,
  // test link
  output jti_pkg::jti_link_t link_out,
  input  wire logic          tdo,
  input  wire logic          tdo_oe
);
  // 25 system cycles per test clock (125 ns), far under the test clock ceiling
  localparam int HALF = 12;

  // test clock stands low between frames; tms and tdi rest at their pull-up level
  initial link_out = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

  // tdo is taken just before the rise, long after the previous fall updated it
  task automatic step(input logic tms, input logic tdi, output logic t);
    @(negedge ref_clk);
    link_out.tms = tms;
    link_out.tdi = tdi;
    repeat (HALF) @(negedge ref_clk);
    // a released tdo reads as the inverse, so an undriven pin cannot pass a compare
    t = tdo_oe ? tdo : ~tdo;
    link_out.tck = 1'b1;
    repeat (HALF) @(negedge ref_clk);
    link_out.tck = 1'b0;
  endtask

  task automatic update();
    logic t;
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask

  task automatic reset_tap();
    logic t;
    repeat (5) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask

  // upd low leaves the port in Exit1-IR so the old instruction can be observed
  task automatic shift_ir(input logic [jti_pkg::IR_W-1:0] code, input logic upd,
                          output logic [jti_pkg::IR_W-1:0] cap);
    logic t;
    step(1'b1, 1'b1, t);
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < jti_pkg::IR_W; i++) begin
      step(i == jti_pkg::IR_W - 1, code[i], t);
      cap[i] = t;
    end
    if (upd) update();
  endtask

  task automatic shift_dr(input int n, input logic [jti_pkg::BSR_LEN-1:0] din,
                          output logic [jti_pkg::BSR_LEN-1:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    update();
  endtask
endmodule // jti_ctl_model

/* File: verification/test_jtag_tap_instruction_logic.sv */
// self-checking bench for the test access port instruction logic
`timescale 1ns/10ps
module test_jtag_tap_instruction_logic;
  localparam int W = jti_pkg::BSR_LEN;
  localparam logic [107:0] P1 = {9{12'h5a3}};
  localparam logic [107:0] P2 = {9{12'hc3e}};
  localparam logic [107:0] P3 = {9{12'h1f0}};

  logic               ref_clk;
  logic               rst_n;
  jti_pkg::jti_link_t link;
  logic               tdo;
  logic               tdo_oe;
  logic [107:0]       pin_in;
  logic [107:0]       pin_drive;
  logic               test_drive;
  logic               rdata_oe;
  logic [2:0]         cap;
  logic [W-1:0]       d;
  int                 n_errors;
  int                 comparisons;

  jti_tap u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_in(link), .tdo_ff(tdo), .tdo_oe_ff(tdo_oe),
    .pin_in(pin_in), .pin_drive_ff(pin_drive), .test_drive_ff(test_drive), .rdata_oe_ff(rdata_oe)
  );
  jti_ctl_model u_ctl (.ref_clk(ref_clk), .link_out(link), .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic t_power_up();
    check("test_drive", W'(test_drive), W'(1'b0));
    check("rdata_oe", W'(rdata_oe), W'(1'b1));
    check("tdo_oe", W'(tdo_oe), W'(1'b0));
    // the port wakes in Test-Logic-Reset; one low tms edge parks it in idle
    u_ctl.step(1'b0, 1'b1, cap[0]);
    u_ctl.shift_dr(jti_pkg::ID_W, '0, d);
    check("idcode", d, W'(jti_pkg::ID_VALUE));
  endtask

  task automatic t_highz();
    u_ctl.shift_ir(jti_pkg::OP_HIGHZ, 1'b0, cap);
    check("ir capture", W'(cap), W'(3'h1));
    check("rdata_oe pre update", W'(rdata_oe), W'(1'b1));
    u_ctl.update();
    check("rdata_oe highz", W'(rdata_oe), W'(1'b0));
    u_ctl.shift_dr(W, '0, d);
    check("highz chain", d, {1'b0, P1});
    check("rdata_oe held", W'(rdata_oe), W'(1'b0));
  endtask

  task automatic t_bypass();
    logic [2:0] codes [4];
    codes = '{jti_pkg::OP_BYPASS, 3'h3, 3'h5, 3'h6};
    foreach (codes[i]) begin
      u_ctl.shift_ir(codes[i], 1'b1, cap);
      u_ctl.shift_dr(4, W'(4'hb), d);
      check("bypass chain", d, W'(4'h6));
      check("rdata_oe bypass", W'(rdata_oe), W'(1'b1));
    end
  endtask

  task automatic t_sample();
    pin_in = P2;
    u_ctl.shift_ir(jti_pkg::OP_SAMPLE, 1'b1, cap);
    check("test_drive sample", W'(test_drive), W'(1'b0));
    u_ctl.shift_dr(W, {1'b1, P3}, d);
    check("sample capture", d, {1'b0, P2});
    check("preload pins", W'(pin_drive), W'(P3));
    check("rdata_oe sample", W'(rdata_oe), W'(1'b1));
    u_ctl.shift_dr(W, {1'b1, P3}, d);
    check("cell capture", d, {1'b1, P2});
  endtask

  task automatic t_extest();
    u_ctl.shift_ir(jti_pkg::OP_EXTEST, 1'b1, cap);
    check("test_drive extest", W'(test_drive), W'(1'b1));
    check("rdata_oe cell one", W'(rdata_oe), W'(1'b1));
    u_ctl.shift_dr(W, {1'b0, P1}, d);
    check("extest chain", d, {1'b1, P2});
    check("rdata_oe cell zero", W'(rdata_oe), W'(1'b0));
    check("extest pins", W'(pin_drive), W'(P1));
    u_ctl.shift_dr(W, {1'b1, P1}, d);
    check("rdata_oe cell back", W'(rdata_oe), W'(1'b1));
  endtask

  task automatic t_logic_reset();
    u_ctl.reset_tap();
    check("test_drive reset", W'(test_drive), W'(1'b0));
    u_ctl.shift_dr(jti_pkg::ID_W, '0, d);
    check("idcode reset", d, W'(jti_pkg::ID_VALUE));
    u_ctl.shift_ir(jti_pkg::OP_EXTEST, 1'b1, cap);
    check("cell cleared", W'(rdata_oe), W'(1'b0));
    check("pins kept", W'(pin_drive), W'(P1));
  endtask

  // power-up reset in mid-run, while extest drives the pins; unlike Test-Logic-Reset it clears them
  task automatic t_mid_reset();
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("test_drive rst", W'(test_drive), W'(1'b0));
    check("rdata_oe rst", W'(rdata_oe), W'(1'b1));
    check("tdo_oe rst", W'(tdo_oe), W'(1'b0));
    check("pins rst", W'(pin_drive), W'(108'h0));
    u_ctl.step(1'b0, 1'b1, cap[0]);
    u_ctl.shift_ir(jti_pkg::OP_EXTEST, 1'b1, cap);
    check("ir capture rst", W'(cap), W'(3'h1));
    check("cell rst", W'(rdata_oe), W'(1'b0));
  endtask

  // whole run is about 19k system cycles; the limit leaves generous room
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  initial begin
    n_errors = 0;
    comparisons = 0;
    rst_n = 1'b0;
    pin_in = P1;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_power_up();
    t_highz();
    t_bypass();
    t_sample();
    t_extest();
    t_logic_reset();
    t_mid_reset();
    give_verdict();
  end
endmodule // test_jtag_tap_instruction_logic
